// >>> logic/cfs_pkg.sv
// cfs_pkg: constants and types of the converter start-up and fault status block
// assumes a 100 MHz pclk; used by cfs_lamp, cfs_status and the testbench
package cfs_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;    // pclk period
  localparam int unsigned FLASH_PERIOD_MS = 2000;  // 0.5 Hz lamp flash
  localparam int unsigned TIME_TICK_MS    = 1;     // fault time stamp unit
  localparam int unsigned CYC_PER_MS      = 1000000 / CLK_PERIOD_NS;
  localparam int unsigned FLASH_HALF_CYC  = FLASH_PERIOD_MS * CYC_PER_MS / 2;
  localparam int unsigned TIME_TICK_CYC   = TIME_TICK_MS * CYC_PER_MS;
  // --------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ALARM  = 8'h08;
  localparam logic [7:0] OFF_FCOUNT = 8'h0C;
  localparam logic [7:0] OFF_FSEL   = 8'h10;
  localparam logic [7:0] OFF_FCODE  = 8'h14;
  localparam logic [7:0] OFF_FVAL   = 8'h18;
  localparam logic [7:0] OFF_FTIME  = 8'h1C;
  // --------------------------------------------------------------
  // fields and reset values
  // --------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;  // card_download_mode [1:0]
  localparam int CTRL_GFE_BIT  = 2;  // group_fault_enable
  localparam int CTRL_ARS_BIT  = 3;  // auto_restart_setting
  localparam int CTRL_FRST_BIT = 4;  // tool fault reset, write one
  localparam int STAT_CARD_BIT = 16; // card present
  localparam int STAT_RUN_BIT  = 17; // start-up finished
  localparam logic [1:0] MODE_NEVER  = 2'h0;
  localparam logic [1:0] MODE_ONCE   = 2'h1;
  localparam logic [1:0] MODE_ALWAYS = 2'h2;
  localparam logic [1:0] MODE_RST    = MODE_ONCE;
  localparam int CW_ON_BIT      = 0;
  localparam int CW_ACK_BIT     = 7;
  localparam int SW_READY_BIT   = 0;
  localparam int SW_ENABLED_BIT = 2;
  localparam int SW_FAULT_BIT   = 3;
  localparam int SW_ALARM_BIT   = 7;
  localparam logic [7:0] PARAM_DATA_SET = 8'h2F; // data set 47
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {LAMP_OFF, LAMP_ON, LAMP_FLASH} cfs_lamp_type;
  typedef enum logic [1:0] {SAFE_IDLE, SAFE_PARAM, SAFE_INIT, SAFE_REACHED} cfs_safe_type;
endpackage

// >>> logic/cfs_mem_if.sv
// cfs_mem_if: port bundle between the status core and the fault memory
// assumes both ends run on the same pclk
`timescale 1ns/10ps
`default_nettype none
interface cfs_mem_if #(parameter int AW = 3, parameter int DW = 64);
  logic          wr_en;   // write strobe
  logic [AW-1:0] wr_addr; // write entry
  logic [DW-1:0] wr_data; // code, value, time
  logic [AW-1:0] rd_addr; // read entry
  logic [DW-1:0] rd_data; // registered read data
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
               output rd_data);
endinterface
`default_nettype wire

// >>> logic/cfs_fault_mem.sv
// cfs_fault_mem: fault history entries with registered read port
// assumes writes and reads come from the status core over cfs_mem_if
`timescale 1ns/10ps
`default_nettype none
module cfs_fault_mem #(
  parameter int AW = 3,
  parameter int DW = 64
) (
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  ce,
  // entry port
  cfs_mem_if.mem     mp
);
  // entry storage, no reset needed
  logic [DW-1:0] mem_q [2**AW];

  // write port
  always_ff @(posedge pclk) begin
    if (ce && mp.wr_en) begin
      mem_q[mp.wr_addr] <= mp.wr_data;
    end
  end

  // registered read port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mp.rd_data <= '0;
    end else if (ce) begin
      mp.rd_data <= mem_q[mp.rd_addr];
    end
  end
endmodule
`default_nettype wire

// >>> logic/cfs_lamp.sv
// cfs_lamp: lamp drivers with on, off and a shared flash phase
// assumes a lamp mode per lamp, two bits each, coded as cfs_lamp_type
`timescale 1ns/10ps
`default_nettype none
module cfs_lamp #(
  parameter int N        = 6,
  parameter int HALF_CYC = cfs_pkg::FLASH_HALF_CYC
) (
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           ce,
  // lamp modes in, lamps out
  input  wire logic [2*N-1:0] mode,
  output logic      [N-1:0]   lamp
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);
  logic [CW-1:0] cnt_q;   // half period counter
  logic          phase_q; // flash phase

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      if (cnt_q == LAST) begin
        phase_q <= ~phase_q;
      end
    end
  end

  // one registered driver per lamp
  for (genvar i = 0; i < N; i++) begin : g_lamp
    cfs_pkg::cfs_lamp_type m;
    assign m = cfs_pkg::cfs_lamp_type'(mode[2*i +: 2]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lamp[i] <= 1'b0;
      end else if (ce) begin
        lamp[i] <= (m == cfs_pkg::LAMP_ON) || ((m == cfs_pkg::LAMP_FLASH) && phase_q);
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/cfs_status.sv
// cfs_status: start-up parameter source choice, alarm and fault stores,
// fault reset, status word and status lamps of a fieldbus converter
// assumes apb master on pclk, a loader that answers load_req with load_done,
// and a fieldbus front end delivering telegram words synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
// Operation
// - mode 0 never loads card
// - mode 1 loads once, then mode 0
// - mode 2 loads card every power-up
// - no card: eeprom start, no fault
// - otherwise copy eeprom into ram
// - card presence decides the download
// - alarm keeps running, code stored, reported
// - alarms unacknowledged, clear with cause
// - fault stops output, red lamp, reported
// - store fault code and value
// - store fault time and count
// - group fault only when enabled
// - control bit 7 resets fault
// - power cycle or tool resets fault
// - lamps on, off, flash 0.5 Hz
// - ready lamp ignores drive running
// - end-state lamp on final state
// - yellow lamps show safety function states
// - cyclic telegram commands and setpoint
// - acyclic access uses data set 47
// - status bit 3 fault, bit 7 alarm
module cfs_status #(
  parameter int DEPTH_LOG2 = 3,
  parameter int FLASH_CYC  = cfs_pkg::FLASH_HALF_CYC,
  parameter int TICK_CYC   = cfs_pkg::TIME_TICK_CYC
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // parameter source
  input  wire logic        card_present,
  input  wire logic [1:0]  nv_mode,
  input  wire logic        load_done,
  output logic             load_req,
  output logic             load_from_card,
  output logic             nv_mode_wr,
  output logic      [1:0]  nv_mode_wdata,
  // cyclic and acyclic fieldbus
  input  wire logic        ctrl_valid,
  input  wire logic [15:0] first_control_word,
  input  wire logic [15:0] setpoint,
  output logic      [15:0] first_status_word,
  output logic      [15:0] freq_setpoint,
  input  wire logic        acyc_req,
  input  wire logic [7:0]  acyc_data_set,
  output logic             acyc_accept,
  output logic             acyc_reject,
  // events and drive
  input  wire logic        alarm_active,
  input  wire logic [15:0] alarm_code,
  input  wire logic        fault_event,
  input  wire logic [15:0] fault_code,
  input  wire logic [15:0] fault_value,
  input  wire logic        converter_ready,
  output logic             output_enable,
  output logic             group_fault,
  // safety function states
  input  wire logic [1:0]  sto_state,
  input  wire logic [1:0]  ss1_state,
  input  wire logic [1:0]  sls_state,
  input  wire logic        safety_final,
  input  wire logic        passivation,
  // lamps
  output logic             system_failure_lamp,
  output logic             ready_lamp,
  output logic             safety_end_state_lamp,
  output logic             torque_off_lamp,
  output logic             controlled_stop_lamp,
  output logic             limited_speed_lamp
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int AW = DEPTH_LOG2;
  localparam logic [AW:0] DEPTH = (AW+1)'(2**AW);
  localparam int TW = $clog2(TICK_CYC + 1);
  typedef enum logic [2:0] {ST_CAPTURE, ST_DECIDE, ST_LOAD_CARD, ST_LOAD_EEPROM,
                            ST_RUN} cfs_boot_type;
  cfs_boot_type  st_q, st_d;      // start-up state
  logic [1:0]    mode_q;          // card_download_mode
  logic          gfe_q;           // group_fault_enable
  logic          ars_q;           // auto_restart_setting
  logic          fault_q;         // fault pending
  logic          armed_q;         // on command allowed after restart
  logic          ack_prev_q;      // last ack bit seen
  logic          nvw_q;           // mode write-back pulse
  logic [1:0]    nvd_q;           // mode write-back value
  logic [15:0]   alarm_q;         // alarm_number_store
  logic [15:0]   cw_q;            // latched control word
  logic [15:0]   sp_q;            // latched setpoint
  logic [15:0]   sw_q;            // first_status_word
  logic [AW:0]   count_q;         // fault_entry_count
  logic [AW-1:0] wptr_q;          // next fault entry
  logic [AW-1:0] sel_q;           // selected entry for reads
  logic [TW-1:0] tick_q;          // time stamp prescaler
  logic [31:0]   time_q;          // fault_time_store source
  logic [31:0]   prdata_q;        // read data
  logic          acc_q, rej_q;    // acyclic answers
  logic [11:0]   lamp_mode;       // packed lamp modes
  logic [5:0]    lamps;           // registered lamps
  cfs_mem_if #(.AW(AW), .DW(64)) mif ();

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire wr_en  = psel && penable && pwrite;
  wire setup  = psel && !penable;
  wire hit    = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  wire w_ctrl = wr_en && (paddr == cfs_pkg::OFF_CTRL);
  wire w_fsel = wr_en && (paddr == cfs_pkg::OFF_FSEL);
  wire tool_rst = w_ctrl && pwdata[cfs_pkg::CTRL_FRST_BIT];
  wire [1:0] w_mode = pwdata[cfs_pkg::CTRL_MODE_LSB +: 2];
  wire [31:0] rdata_mux =
    (paddr == cfs_pkg::OFF_CTRL)   ? {28'h0, ars_q, gfe_q, mode_q} :
    (paddr == cfs_pkg::OFF_STATUS) ? {14'h0, st_q == ST_RUN, card_present, sw_q} :
    (paddr == cfs_pkg::OFF_ALARM)  ? {16'h0, alarm_q} :
    (paddr == cfs_pkg::OFF_FCOUNT) ? {{(31-AW){1'b0}}, count_q} :
    (paddr == cfs_pkg::OFF_FSEL)   ? {{(32-AW){1'b0}}, sel_q} :
    (paddr == cfs_pkg::OFF_FCODE)  ? {16'h0, mif.rd_data[63:48]} :
    (paddr == cfs_pkg::OFF_FVAL)   ? {16'h0, mif.rd_data[47:32]} :
    (paddr == cfs_pkg::OFF_FTIME)  ? mif.rd_data[31:0] : 32'h0;
  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (ce && setup) begin
      prdata_q <= hit ? rdata_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // start-up source selection
  // ----------------------------------------------------------------
  // mode 2 loads, setting kept
  wire card_go = (mode_q != cfs_pkg::MODE_NEVER) && card_present;
  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_CAPTURE: st_d = ST_DECIDE;
      ST_DECIDE: st_d = card_go ? ST_LOAD_CARD : ST_LOAD_EEPROM;
      ST_LOAD_CARD: if (load_done) st_d = ST_RUN;
      ST_LOAD_EEPROM: if (load_done) st_d = ST_RUN;
      ST_RUN: st_d = ST_RUN;
      default: st_d = ST_CAPTURE;
    endcase
  end
  assign load_req       = (st_q == ST_LOAD_CARD) || (st_q == ST_LOAD_EEPROM);
  assign load_from_card = (st_q == ST_LOAD_CARD);
  assign nv_mode_wr     = nvw_q;
  assign nv_mode_wdata  = nvd_q;

  // state, mode and settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_CAPTURE;
      mode_q <= cfs_pkg::MODE_RST;
      gfe_q  <= 1'b0;
      ars_q  <= 1'b0;
      nvw_q  <= 1'b0;
      nvd_q  <= cfs_pkg::MODE_RST;
    end else if (ce) begin
      st_q  <= st_d;
      nvw_q <= 1'b0;
      if (st_q == ST_CAPTURE) begin
        mode_q <= nv_mode;
      end else if (st_q == ST_LOAD_CARD && load_done && mode_q == cfs_pkg::MODE_ONCE) begin
        mode_q <= cfs_pkg::MODE_NEVER;
        nvw_q  <= 1'b1;
        nvd_q  <= cfs_pkg::MODE_NEVER;
      end else if (w_ctrl) begin
        mode_q <= w_mode;
        nvw_q  <= 1'b1;
        nvd_q  <= w_mode;
      end
      if (w_ctrl) begin
        gfe_q <= pwdata[cfs_pkg::CTRL_GFE_BIT];
        ars_q <= pwdata[cfs_pkg::CTRL_ARS_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // cyclic telegram, alarms, faults
  // ----------------------------------------------------------------
  // telegram words steer the drive
  wire cw_on  = cw_q[cfs_pkg::CW_ON_BIT];
  wire ack_in = ctrl_valid && first_control_word[cfs_pkg::CW_ACK_BIT];
  wire ack_edge = ack_in && !ack_prev_q;
  wire fault_clr = ack_edge || tool_rst;
  assign freq_setpoint     = sp_q;
  assign first_status_word = sw_q;
  assign acyc_accept       = acc_q;
  assign acyc_reject       = rej_q;

  // telegram latch and fault state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw_q       <= 16'h0;
      sp_q       <= 16'h0;
      ack_prev_q <= 1'b0;
      fault_q    <= 1'b0;
      armed_q    <= 1'b0;
      alarm_q    <= 16'h0;
    end else if (ce) begin
      if (ctrl_valid) begin
        cw_q       <= first_control_word;
        sp_q       <= setpoint;
        ack_prev_q <= first_control_word[cfs_pkg::CW_ACK_BIT];
      end
      // tool reset, reset is power cycle
      if (fault_event) begin
        fault_q <= 1'b1;
      end else if (fault_clr) begin
        fault_q <= 1'b0;
      end
      // first start needs on bit low unless auto; armed_q never clears, restart after fault needs no on edge
      if (ars_q || (ctrl_valid && !first_control_word[cfs_pkg::CW_ON_BIT])) begin
        armed_q <= 1'b1;
      end
      alarm_q <= alarm_active ? alarm_code : 16'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 1'b0;
      rej_q <= 1'b0;
    end else if (ce) begin
      acc_q <= acyc_req && (acyc_data_set == cfs_pkg::PARAM_DATA_SET);
      rej_q <= acyc_req && (acyc_data_set != cfs_pkg::PARAM_DATA_SET);
    end
  end

  // status word, output stage, group fault
  wire run = (st_q == ST_RUN);
  wire en_d = run && !fault_q && !fault_event && cw_on && armed_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q          <= 16'h0;
      output_enable <= 1'b0;
      group_fault   <= 1'b0;
    end else if (ce) begin
      output_enable <= en_d;
      group_fault <= (fault_q || fault_event) && gfe_q;
      sw_q <= 16'h0;
      sw_q[cfs_pkg::SW_READY_BIT]   <= run && converter_ready;
      sw_q[cfs_pkg::SW_ENABLED_BIT] <= en_d;
      // fault bit 3, alarm bit 7
      sw_q[cfs_pkg::SW_FAULT_BIT] <= fault_q || fault_event;
      sw_q[cfs_pkg::SW_ALARM_BIT] <= alarm_active;
    end
  end

  // ----------------------------------------------------------------
  // fault history
  // ----------------------------------------------------------------
  // code and value, value 0 if none
  assign mif.wr_en   = fault_event;
  assign mif.wr_addr = wptr_q;
  assign mif.wr_data = {fault_code, fault_value, time_q};
  assign mif.rd_addr = w_fsel ? pwdata[AW-1:0] : sel_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q  <= '0;
      time_q  <= 32'h0;
      count_q <= '0;
      wptr_q  <= '0;
      sel_q   <= '0;
    end else if (ce) begin
      tick_q <= (tick_q == TW'(TICK_CYC - 1)) ? '0 : tick_q + 1'b1;
      if (tick_q == TW'(TICK_CYC - 1)) begin
        time_q <= time_q + 32'h1;
      end
      if (fault_event) begin
        wptr_q <= wptr_q + 1'b1;
        if (count_q != DEPTH) begin
          count_q <= count_q + 1'b1;
        end
      end
      if (w_fsel) begin
        sel_q <= pwdata[AW-1:0];
      end
    end
  end

  cfs_fault_mem #(.AW(AW), .DW(64)) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .mp      (mif.mem)
  );

  // ----------------------------------------------------------------
  // lamps
  // ----------------------------------------------------------------
  // param on, initiated flash, reached on
  function automatic logic [1:0] safe_lamp(input logic [1:0] s, input logic pas);
    logic [1:0] r;
    r = cfs_pkg::LAMP_OFF;
    if (pas || s == cfs_pkg::SAFE_INIT) begin
      r = cfs_pkg::LAMP_FLASH;
    end else if (s != cfs_pkg::SAFE_IDLE) begin
      r = cfs_pkg::LAMP_ON;
    end
    return r;
  endfunction
  assign lamp_mode[1:0] = fault_q ? cfs_pkg::LAMP_ON : cfs_pkg::LAMP_OFF;
  assign lamp_mode[3:2] = load_from_card ? cfs_pkg::LAMP_FLASH :
                          (run && converter_ready) ? cfs_pkg::LAMP_ON : cfs_pkg::LAMP_OFF;
  assign lamp_mode[5:4] = safety_final ? cfs_pkg::LAMP_ON : cfs_pkg::LAMP_OFF;
  assign lamp_mode[7:6]   = safe_lamp(sto_state, passivation);
  assign lamp_mode[9:8]   = safe_lamp(ss1_state, passivation);
  assign lamp_mode[11:10] = safe_lamp(sls_state, passivation);

  cfs_lamp #(.N(6), .HALF_CYC(FLASH_CYC)) u_lamp (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .mode    (lamp_mode),
    .lamp    (lamps)
  );
  assign system_failure_lamp   = lamps[0];
  assign ready_lamp            = lamps[1];
  assign safety_end_state_lamp = lamps[2];
  assign torque_off_lamp       = lamps[3];
  assign controlled_stop_lamp  = lamps[4];
  assign limited_speed_lamp    = lamps[5];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire dec = ce && (st_q == ST_DECIDE);
  property p_never_card;
    dec && mode_q == cfs_pkg::MODE_NEVER |=> st_q == ST_LOAD_EEPROM;
  endproperty
  a_never_card: assert property (p_never_card) else $error("mode 0 loaded card");
  property p_once;
    ce && st_q == ST_LOAD_CARD && load_done && mode_q == cfs_pkg::MODE_ONCE
      |=> mode_q == cfs_pkg::MODE_NEVER && nv_mode_wr && nv_mode_wdata == cfs_pkg::MODE_NEVER;
  endproperty
  a_once: assert property (p_once) else $error("mode 1 not cleared");
  property p_always;
    dec && mode_q == cfs_pkg::MODE_ALWAYS && card_present |=> load_from_card ##1 !nv_mode_wr;
  endproperty
  a_always: assert property (p_always) else $error("mode 2 no card load");
  property p_nocard;
    dec && !card_present |=> load_req && !load_from_card && !fault_q;
  endproperty
  a_nocard: assert property (p_nocard) else $error("no card start wrong");
  property p_fault;
    ce && fault_event |=> !output_enable && first_status_word[cfs_pkg::SW_FAULT_BIT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not reported");
  property p_alarm;
    ce && !alarm_active |=> alarm_q == 16'h0 && !first_status_word[cfs_pkg::SW_ALARM_BIT];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not cleared");
  property p_group;
    group_fault |-> $past(gfe_q);
  endproperty
  a_group: assert property (p_group) else $error("group fault ungated");
  property p_ack;
    ce && ack_edge && !fault_event |=> !fault_q;
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear");
  property p_count;
    ce && fault_event && count_q != DEPTH |=> count_q == $past(count_q) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("fault count wrong");
  c_card: cover property (dec ##1 st_q == ST_LOAD_CARD);
  c_fault_ack: cover property (fault_q ##[1:50] !fault_q);
  c_alarm: cover property (alarm_active ##1 !alarm_active);
endmodule
`default_nettype wire

// >>> verif/cfs_plc.sv
// cfs_plc: fieldbus controller model sending cyclic telegrams
// assumes the bench sets the command word to be sent
`timescale 1ns/10ps
`default_nettype none
module cfs_plc (
  // clock and command
  input  wire logic        pclk,
  input  wire logic [15:0] cw,
  // telegram out
  output logic             ctrl_valid,
  output logic      [15:0] first_control_word,
  output logic      [15:0] setpoint
);
  // --------------------------------
  // telegram timing
  // --------------------------------
  logic [2:0] gap_q = '0; // cycles between telegrams
  always @(posedge pclk) gap_q <= gap_q + 3'h1;
  assign ctrl_valid = (gap_q == 3'h7);
  // bit 7 carries the fault ack; junk between telegrams
  assign first_control_word = ctrl_valid ? cw : ~cw;
  assign setpoint = ctrl_valid ? cw ^ 16'h5A5A : cw;
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// testbench: cfs_status over apb, pins and the cfs_plc model
// assumes shortened flash and time tick counts
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // --------------------------------
  // signals and instances
  // --------------------------------
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, err, lamp_a;
  logic card_present = '0, load_done = '0, acyc_req = '0, alarm_active = '0;
  logic fault_event = '0, converter_ready = '0, ctrl_valid, pready, pslverr;
  logic load_req, load_from_card, nv_mode_wr, acyc_accept, acyc_reject, group_fault;
  logic output_enable, system_failure_lamp, ready_lamp, torque_off_lamp, safety_end_state_lamp;
  logic controlled_stop_lamp, limited_speed_lamp, safety_final = '0, passivation = '0;
  logic [1:0]  nv_mode = '0, sto_state = '0, nv_mode_wdata, ss1_state = '0, sls_state = '0;
  logic [7:0]  paddr = '0, acyc_data_set = '0;
  logic [15:0] cw = '0, alarm_code = '0, fault_code = 16'h0003, fault_value = '0;
  logic [15:0] first_status_word, freq_setpoint, first_control_word, setpoint;
  logic [31:0] pwdata = '0, prdata, rd;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  logic [1:0]  mt [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1}; // boot modes
  localparam logic [4:0] CT = 5'h07, LC = 5'h06, WR = 5'h02; // card, source, rewrite
  cfs_status #(.FLASH_CYC(4), .TICK_CYC(3)) i_cfs_status (.*, .ce(1'h1));
  cfs_plc i_cfs_plc (.*);
  initial forever #5 pclk = ~pclk;
  // wait n edges
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    tk(1);
    penable <= 1'h1;
    do tk(1); while (pready !== 1'h1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    tk(1);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    for (int i = 0; i < 5; i++) begin
      {presetn, nv_mode, card_present} <= {1'h0, mt[i], CT[i]};
      tk(10);
      presetn <= 1'h1;
      tk(4);
      chk("src", {1'h1, LC[i]}, {load_req, load_from_card});
      load_done <= 1'h1;
      tk(1);
      load_done <= 1'h0;
      tk(1);
      chk("wr", {WR[i], 2'h0}, {nv_mode_wr, WR[i] ? nv_mode_wdata : 2'h0});
      apb(1'h0, cfs_pkg::OFF_CTRL, '0);
      chk("mode", WR[i] ? 2'h0 : mt[i], rd[1:0]);
    end
    {converter_ready, sto_state} <= 3'h5;
    tk(12);
    cw <= 16'h0001;
    tk(20);
    chk("run", 20'hF5A5B, {output_enable, ready_lamp, first_status_word[0],
        torque_off_lamp, freq_setpoint});
    sto_state <= 2'h2;
    tk(3);
    lamp_a = torque_off_lamp;
    tk(4);
    chk("flash", {~lamp_a}, torque_off_lamp);
    {safety_final, ss1_state, sls_state} <= 5'h1D;
    tk(3);
    chk("safe_on", 3'h7, {safety_end_state_lamp, controlled_stop_lamp,
        limited_speed_lamp});
    passivation <= 1'h1;
    tk(3);
    lamp_a = limited_speed_lamp;
    tk(4);
    chk("passiv", {~lamp_a}, limited_speed_lamp);
    passivation <= 1'h0;
    {fault_event, fault_value} <= 17'h10024;
    tk(1);
    fault_event <= 1'h0;
    tk(3);
    chk("fault", 4'h6, {output_enable, system_failure_lamp, first_status_word[3],
        group_fault});
    apb(1'h0, cfs_pkg::OFF_FCOUNT, '0);
    chk("count", 32'h1, rd);
    apb(1'h1, cfs_pkg::OFF_FSEL, '0);
    apb(1'h0, cfs_pkg::OFF_FCODE, '0);
    chk("code", 32'h3, rd);
    apb(1'h0, cfs_pkg::OFF_FVAL, '0);
    chk("value", 32'h24, rd);
    cw <= 16'h0081;
    tk(20);
    chk("ack", 2'h2, {output_enable, first_status_word[3]});
    {alarm_active, alarm_code} <= 17'h101F7;
    tk(2);
    chk("alarm", 2'h3, {output_enable, first_status_word[7]});
    apb(1'h0, cfs_pkg::OFF_ALARM, '0);
    chk("alarm_no", 32'h1F7, rd);
    alarm_active <= 1'h0;
    tk(2);
    chk("alarm_clr", 1'h0, first_status_word[7]);
    apb(1'h1, cfs_pkg::OFF_CTRL, 32'h5);
    {fault_event, fault_code} <= 17'h10005;
    tk(1);
    fault_event <= 1'h0;
    tk(2);
    chk("gf_on", 2'h3, {group_fault, first_status_word[3]});
    apb(1'h1, cfs_pkg::OFF_CTRL, 32'h15);
    tk(2);
    chk("tool_rst", 2'h0, {group_fault, first_status_word[3]});
    for (int i = 46; i < 48; i++) begin
      {acyc_req, acyc_data_set} <= {1'h1, i[7:0]};
      tk(1);
      acyc_req <= 1'h0;
      tk(1);
      chk("acyc", {i == 47, i != 47}, {acyc_accept, acyc_reject});
    end
    apb(1'h0, 8'h20, '0);
    chk("unmapped", 1'h1, err);
    close_out();
  end
endmodule
`default_nettype wire
